// *** core/d_channel_hdlc_map.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef D_CHANNEL_HDLC_MAP_SVH
`define D_CHANNEL_HDLC_MAP_SVH
`define RX_FIFO_OFS 6'h00
`define TX_FIFO_OFS 6'h01
`define CMD_OFS 6'h02
`define MODE_OFS 6'h03
`define STAT_OFS 6'h04
`define MASK_OFS 6'h05
`define EXT_OFS 6'h06
`define RXCNT_OFS 6'h17
`define T1CFG_OFS 6'h38
`define CMD_RX_ACKNOWLEDGE 7
`define CMD_RX_RESET_CMD 6
`define CMD_TIMER1_START 4
`define CMD_XMS 3
`define CMD_XME 1
`define CMD_TX_RESET_CMD 0
`define MODE_RXACT 6
`define MODE_TXACT 5
`define MODE_LOOPD 3
`define MODE_MFOFF 2
`define MODE_DLOOP 1
`define MODE_LOOPB 0
`define MODE_RW 8'h6f
`define ST_RMR 7
`define ST_RME 6
`define ST_XFR 5
`define ST_PINB 4
`define ST_PINA 3
`define ST_EXI 2
`define ST_B1 1
`define ST_B2 0
`define EX_RX_OVERFLOW 7
`define EX_TX_UNDERRUN 6
`define EX_TX_COLLISION 5
`define EX_TIMER2_EXPIRED 4
`define EX_GCI 3
`define EX_T1 1
`define MASK_RESET 8'hff
`define FIFO_DEPTH 7'd64
`define BLOCK_LEN 7'd32
`define FLAG_BYTE 8'h7e
`define FILL_BYTE 8'hff
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h8408
`define CLOCK_NS 25
`define T1_UNIT_NS 1000000
`endif

// *** core/d_channel_hdlc_pkg.sv ***
// types shared by the d-channel hdlc register block
package d_channel_hdlc_pkg;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_FLAG = 5'h02,
    TX_DATA = 5'h04,
    TX_FCS2 = 5'h08,
    TX_CLOSE = 5'h10
  } txState_type;
  typedef struct packed {
    logic rxValid;
    logic [7:0] rxByte;
    logic rxEnd;
    logic txTake;
    logic collision;
    logic timer2Zero;
    logic pinA;
    logic pinB;
    logic b1Sum;
    logic b2Sum;
    logic gciSum;
  } lineIn_type;
  typedef struct packed {
    logic [7:0] txByte;
    logic txValid;
    logic rxActive;
    logic txActive;
    logic lineLoopWithDch;
    logic multiframeOff;
    logic digitalLoopback;
    logic lineLoopBOnly;
    logic timer1Run;
  } lineOut_type;
  typedef struct packed {
    lineIn_type sync1;
    lineIn_type sync2;
    lineIn_type prev;
    logic [63:0][7:0] rxMem;
    logic [5:0] rxWp;
    logic [5:0] rxRp;
    logic [6:0] rxCnt;
    logic [6:0] unpres;
    logic [6:0] presLeft;
    logic presenting;
    logic endPend;
    logic [12:0] frameLen;
    logic [7:0] countLow;
    logic [63:0][7:0] txMem;
    logic [5:0] txWp;
    logic [5:0] txRp;
    logic [6:0] txCnt;
    logic txEnd;
    txState_type txSt;
    logic [15:0] crc;
    logic xfrArm;
    logic xfrWhole;
    logic initXfr;
    logic [7:0] mode;
    logic [7:0] mask;
    logic [7:0] stat;
    logic [7:0] ext;
    logic [7:0] t1Cfg;
    logic [7:0] t1Cnt;
    logic [15:0] t1Pre;
    logic t1Run;
    logic [7:0] rdata;
    logic irq;
    lineOut_type out;
  } state_type;
endpackage : d_channel_hdlc_pkg

// *** core/d_channel_hdlc_regs.sv ***
// d-channel hdlc controller: fifos, commands, mode and interrupt registers
`timescale 1ns/1ps
`include "d_channel_hdlc_map.svh"
module d_channel_hdlc_regs #(
  parameter int T1_UNIT_CYCLES = `T1_UNIT_NS / `CLOCK_NS
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq,
  input wire d_channel_hdlc_pkg::lineIn_type lineIn,
  output d_channel_hdlc_pkg::lineOut_type lineOut
);
  d_channel_hdlc_pkg::state_type s_q;
  d_channel_hdlc_pkg::state_type s_d;
  logic rxStb;
  logic endStb;
  logic txPull;
  logic wrCmd;

  // hdlc fcs, bits taken lsb first as they leave on the line
  function automatic logic [15:0] crcStep(input logic [15:0] c,
                                          input logic [7:0] b);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[0] ^ b[i];
      r = {1'b0, r[15:1]};
      if (fb) begin
        r = r ^ `CRC_POLY;
      end
    end
    return r;
  endfunction : crcStep

  assign rdata = s_q.rdata;
  assign irq = s_q.irq;
  assign lineOut = s_q.out;
  // strobes are edges of the second sync stage, never the first
  assign rxStb = s_q.sync2.rxValid & ~s_q.prev.rxValid;
  assign endStb = s_q.sync2.rxEnd & ~s_q.prev.rxEnd;
  assign txPull = s_q.sync2.txTake & ~s_q.prev.txTake;
  assign wrCmd = wr && addr == `CMD_OFS;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = lineIn;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    s_d.out.txValid = 1'b0;
    s_d.rdata = 8'h00;
    // register reads; the read clears come before any hardware set
    if (rd) begin
      case (addr)
        `RX_FIFO_OFS: begin
          if (s_q.presLeft != 7'd0) begin
            s_d.rdata = s_q.rxMem[s_q.rxRp];
            s_d.rxRp = s_q.rxRp + 6'd1;
            s_d.rxCnt = s_d.rxCnt - 7'd1;
            s_d.presLeft = s_q.presLeft - 7'd1;
          end
        end
        `MODE_OFS: s_d.rdata = s_q.mode;
        `STAT_OFS: begin
          s_d.rdata = s_q.stat & ~s_q.mask;
          s_d.stat = s_q.stat & s_q.mask;
        end
        `MASK_OFS: s_d.rdata = s_q.mask;
        `EXT_OFS: begin
          if (!s_q.mask[`ST_EXI]) begin
            s_d.rdata = s_q.ext;
            s_d.ext = 8'h00;
          end
        end
        `RXCNT_OFS: s_d.rdata = s_q.countLow;
        `T1CFG_OFS: s_d.rdata = s_q.t1Cfg;
        default: s_d.rdata = 8'h00;
      endcase
    end
    if (wr) begin
      case (addr)
        `TX_FIFO_OFS: begin
          // a full buffer drops the byte; host keeps the 32/64 budget
          if (s_q.txCnt != `FIFO_DEPTH) begin
            s_d.txMem[s_q.txWp] = wdata;
            s_d.txWp = s_q.txWp + 6'd1;
            s_d.txCnt = s_q.txCnt + 7'd1;
          end
        end
        `MODE_OFS: s_d.mode = wdata & `MODE_RW;
        `MASK_OFS: s_d.mask = wdata;
        `T1CFG_OFS: begin
          s_d.t1Cfg = wdata;
          s_d.t1Run = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // commands act only on ones and are never stored
    if (wrCmd) begin
      if (wdata[`CMD_RX_ACKNOWLEDGE] && s_q.presenting) begin
        s_d.rxRp = s_d.rxRp + s_d.presLeft[5:0];
        s_d.rxCnt = s_d.rxCnt - s_d.presLeft;
        s_d.presLeft = 7'd0;
        s_d.presenting = 1'b0;
      end
      if (wdata[`CMD_TIMER1_START]) begin
        s_d.t1Run = 1'b1;
        s_d.t1Cnt = s_q.t1Cfg;
        s_d.t1Pre = 16'h0000;
      end
      if (wdata[`CMD_XMS] && s_q.mode[`MODE_TXACT]
          && s_q.txSt == d_channel_hdlc_pkg::TX_IDLE) begin
        s_d.txSt = d_channel_hdlc_pkg::TX_FLAG;
        s_d.crc = `CRC_INIT;
      end
      if (wdata[`CMD_XMS] && s_q.mode[`MODE_TXACT]) begin
        if (wdata[`CMD_XME]) begin
          s_d.xfrWhole = 1'b1;
        end else begin
          s_d.xfrArm = 1'b1;
        end
      end
      if (wdata[`CMD_XME]) begin
        s_d.txEnd = 1'b1;
      end
    end
    // timer 1 counts down in units of the prescaler
    if (s_d.t1Run && !(wrCmd && wdata[`CMD_TIMER1_START])) begin
      if (s_q.t1Pre == 16'(T1_UNIT_CYCLES - 1)) begin
        s_d.t1Pre = 16'h0000;
        if (s_q.t1Cnt <= 8'h01) begin
          s_d.t1Run = 1'b0;
          s_d.ext[`EX_T1] = 1'b1;
        end else begin
          s_d.t1Cnt = s_q.t1Cnt - 8'h01;
        end
      end else begin
        s_d.t1Pre = s_q.t1Pre + 16'h0001;
      end
    end
    // receive side; the byte is expected stable before its strobe
    if (rxStb && s_q.mode[`MODE_RXACT]) begin
      if (s_q.endPend) begin
        s_d.ext[`EX_RX_OVERFLOW] = 1'b1;
      end else begin
        s_d.rxMem[s_q.rxWp] = s_q.sync2.rxByte;
        s_d.rxWp = s_q.rxWp + 6'd1;
        s_d.frameLen = s_q.frameLen + 13'd1;
        if (s_d.rxCnt == `FIFO_DEPTH) begin
          s_d.ext[`EX_RX_OVERFLOW] = 1'b1;
          s_d.rxRp = s_d.rxRp + 6'd1;
        end else begin
          s_d.rxCnt = s_d.rxCnt + 7'd1;
        end
        if (s_q.unpres != `FIFO_DEPTH) begin
          s_d.unpres = s_q.unpres + 7'd1;
        end
      end
    end
    if (endStb && s_q.mode[`MODE_RXACT] && !s_q.endPend) begin
      s_d.endPend = 1'b1;
    end
    // one block is shown to the host at a time
    if (!s_d.presenting) begin
      if (s_d.unpres >= `BLOCK_LEN) begin
        s_d.presenting = 1'b1;
        s_d.presLeft = `BLOCK_LEN;
        s_d.unpres = s_d.unpres - `BLOCK_LEN;
        s_d.stat[`ST_RMR] = 1'b1;
      end else if (s_d.endPend) begin
        s_d.endPend = 1'b0;
        s_d.countLow = s_d.frameLen[7:0];
        s_d.frameLen = 13'd0;
        if (s_d.unpres != 7'd0) begin
          s_d.presenting = 1'b1;
          s_d.presLeft = s_d.unpres;
          s_d.unpres = 7'd0;
          s_d.stat[`ST_RME] = 1'b1;
        end
      end
    end
    // receiver reset wins over a byte landing in the same cycle
    if (wrCmd && wdata[`CMD_RX_RESET_CMD]) begin
      s_d.rxWp = 6'd0;
      s_d.rxRp = 6'd0;
      s_d.rxCnt = 7'd0;
      s_d.unpres = 7'd0;
      s_d.presLeft = 7'd0;
      s_d.presenting = 1'b0;
      s_d.endPend = 1'b0;
      s_d.frameLen = 13'd0;
    end
    // transmit side, one byte per pull from the line
    if (txPull) begin
      s_d.out.txValid = 1'b1;
      s_d.out.txByte = `FILL_BYTE;
      case (s_q.txSt)
        d_channel_hdlc_pkg::TX_IDLE: s_d.out.txByte = `FILL_BYTE;
        d_channel_hdlc_pkg::TX_FLAG: begin
          s_d.out.txByte = `FLAG_BYTE;
          s_d.txSt = d_channel_hdlc_pkg::TX_DATA;
        end
        d_channel_hdlc_pkg::TX_DATA: begin
          if (s_d.txCnt != 7'd0) begin
            s_d.out.txByte = s_d.txMem[s_d.txRp];
            s_d.crc = crcStep(s_q.crc, s_d.txMem[s_d.txRp]);
            s_d.txRp = s_d.txRp + 6'd1;
            s_d.txCnt = s_d.txCnt - 7'd1;
          end else if (s_d.txEnd) begin
            s_d.out.txByte = ~s_q.crc[7:0];
            s_d.txSt = d_channel_hdlc_pkg::TX_FCS2;
          end else begin
            s_d.ext[`EX_TX_UNDERRUN] = 1'b1;
            s_d.txSt = d_channel_hdlc_pkg::TX_IDLE;
            s_d.txEnd = 1'b0;
            s_d.xfrArm = 1'b0;
            s_d.xfrWhole = 1'b0;
            s_d.stat[`ST_XFR] = 1'b1;
          end
        end
        d_channel_hdlc_pkg::TX_FCS2: begin
          s_d.out.txByte = ~s_q.crc[15:8];
          s_d.txSt = d_channel_hdlc_pkg::TX_CLOSE;
        end
        d_channel_hdlc_pkg::TX_CLOSE: begin
          s_d.out.txByte = `FLAG_BYTE;
          s_d.txSt = d_channel_hdlc_pkg::TX_IDLE;
          s_d.txEnd = 1'b0;
          if (s_q.xfrWhole) begin
            s_d.stat[`ST_XFR] = 1'b1;
            s_d.xfrWhole = 1'b0;
          end
        end
        default: s_d.txSt = d_channel_hdlc_pkg::TX_IDLE;
      endcase
    end
    // a collision mid-frame drops the frame; fill resumes at once
    if (s_q.sync2.collision && !s_q.prev.collision
        && s_q.txSt != d_channel_hdlc_pkg::TX_IDLE) begin
      s_d.ext[`EX_TX_COLLISION] = 1'b1;
      s_d.txSt = d_channel_hdlc_pkg::TX_IDLE;
      s_d.txWp = 6'd0;
      s_d.txRp = 6'd0;
      s_d.txCnt = 7'd0;
      s_d.txEnd = 1'b0;
      s_d.xfrArm = 1'b0;
      s_d.xfrWhole = 1'b0;
      s_d.stat[`ST_XFR] = 1'b1;
    end
    if (wrCmd && wdata[`CMD_TX_RESET_CMD]) begin
      s_d.txSt = d_channel_hdlc_pkg::TX_IDLE;
      s_d.txWp = 6'd0;
      s_d.txRp = 6'd0;
      s_d.txCnt = 7'd0;
      s_d.txEnd = 1'b0;
      s_d.xfrArm = 1'b0;
      s_d.xfrWhole = 1'b0;
      s_d.stat[`ST_XFR] = 1'b1;
    end
    if (s_d.xfrArm && s_d.txCnt <= `BLOCK_LEN) begin
      s_d.xfrArm = 1'b0;
      s_d.stat[`ST_XFR] = 1'b1;
    end
    if (s_q.initXfr) begin
      s_d.initXfr = 1'b0;
      s_d.stat[`ST_XFR] = 1'b1;
    end
    // external sources; these sets come after the read clears
    if (s_q.sync2.pinB && !s_q.prev.pinB) begin
      s_d.stat[`ST_PINB] = 1'b1;
    end
    if (s_q.sync2.pinA && !s_q.prev.pinA) begin
      s_d.stat[`ST_PINA] = 1'b1;
    end
    s_d.stat[`ST_B1] = s_d.stat[`ST_B1] | s_q.sync2.b1Sum;
    s_d.stat[`ST_B2] = s_d.stat[`ST_B2] | s_q.sync2.b2Sum;
    if (s_q.sync2.timer2Zero && !s_q.prev.timer2Zero) begin
      s_d.ext[`EX_TIMER2_EXPIRED] = 1'b1;
    end
    s_d.ext[`EX_GCI] = s_d.ext[`EX_GCI] | s_q.sync2.gciSum;
    s_d.stat[`ST_EXI] = |s_d.ext;
    s_d.irq = |(s_d.stat & ~s_d.mask);
    s_d.out.rxActive = s_d.mode[`MODE_RXACT];
    s_d.out.txActive = s_d.mode[`MODE_TXACT];
    s_d.out.lineLoopWithDch = s_d.mode[`MODE_LOOPD];
    s_d.out.multiframeOff = s_d.mode[`MODE_MFOFF];
    // the line side may need its clocks enabled before this loop works
    s_d.out.digitalLoopback = s_d.mode[`MODE_DLOOP];
    s_d.out.lineLoopBOnly = s_d.mode[`MODE_LOOPB];
    s_d.out.timer1Run = s_d.t1Run;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.mask <= `MASK_RESET;
      s_q.txSt <= d_channel_hdlc_pkg::TX_IDLE;
      s_q.initXfr <= 1'b1;
      s_q.out.txByte <= `FILL_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  sequence pullInState(d_channel_hdlc_pkg::txState_type st);
    txPull && s_q.txSt == st;
  endsequence

  rx_thresh_a: assert property (
    $rose(s_q.stat[`ST_RMR]) |-> s_q.presLeft == 7'd32)
    else $error("threshold block is not 32 bytes");
  rx_end_len_a: assert property (
    $rose(s_q.stat[`ST_RME]) && !s_q.ext[`EX_RX_OVERFLOW] |->
      s_q.presLeft == ((s_q.countLow[4:0] == 5'd0) ? 7'd32 :
                       {2'b00, s_q.countLow[4:0]}))
    else $error("frame end length mismatch");
  cmd_zero_a: assert property (
    wrCmd && wdata == 8'h00 && s_q.txSt == d_channel_hdlc_pkg::TX_IDLE
      && !txPull && !s_q.t1Run |=>
      s_q.txSt == d_channel_hdlc_pkg::TX_IDLE && !s_q.t1Run)
    else $error("zero command had an effect");
  rx_reset_a: assert property (
    wrCmd && wdata[`CMD_RX_RESET_CMD] |=>
      s_q.rxCnt == 7'd0 && !s_q.presenting && s_q.unpres == 7'd0)
    else $error("receiver reset kept data");
  // the run pin is registered from the same next state as the run flag
  timer_start_a: assert property (
    wrCmd && wdata[`CMD_TIMER1_START] |=> s_q.t1Run && s_q.out.timer1Run)
    else $error("timer 1 did not start");
  timer_cfg_stop_a: assert property (
    wr && addr == `T1CFG_OFS |=> !s_q.t1Run)
    else $error("timer 1 kept running after config write");
  tx_flag_first_a: assert property (
    pullInState(d_channel_hdlc_pkg::TX_FLAG) |=>
      s_q.out.txValid && s_q.out.txByte == `FLAG_BYTE)
    else $error("opening flag missing");
  tx_reset_a: assert property (
    wrCmd && wdata[`CMD_TX_RESET_CMD] |=> s_q.txCnt == 7'd0 && s_q.stat[`ST_XFR]
      && s_q.txSt == d_channel_hdlc_pkg::TX_IDLE)
    else $error("transmitter reset incomplete");
  stat_read_a: assert property (
    rd && addr == `STAT_OFS |=>
      s_q.rdata == ($past(s_q.stat) & ~$past(s_q.mask)))
    else $error("status read value wrong");
endmodule : d_channel_hdlc_regs

// *** dv/line_model.sv ***
// line-side partner: received bytes, frame ends, takes and event sources
`timescale 1ns/1ps
module line_model (
  input wire logic clock,
  output d_channel_hdlc_pkg::lineIn_type lineIn
);
  initial lineIn = '0;
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask : hold
  // byte settles long before its strobe: the block samples through two flops
  task automatic sendByte(input logic [7:0] b);
    lineIn.rxByte <= b;
    hold(4);
    lineIn.rxValid <= 1'b1;
    hold(4);
    lineIn.rxValid <= 1'b0;
    lineIn.rxByte <= ~b;
    hold(4);
  endtask : sendByte
  task automatic sendEnd();
    lineIn.rxEnd <= 1'b1;
    hold(4);
    lineIn.rxEnd <= 1'b0;
    hold(4);
  endtask : sendEnd
  // the line pulls bytes at its own pace, slower than the block needs
  task automatic takes(input int n);
    repeat (n) begin
      lineIn.txTake <= 1'b1;
      hold(4);
      lineIn.txTake <= 1'b0;
      hold(4);
    end
  endtask : takes
  task automatic setSrc(input int i, input logic v);
    case (i)
      0: lineIn.timer2Zero <= v;
      1: lineIn.pinA <= v;
      2: lineIn.pinB <= v;
      3: lineIn.b1Sum <= v;
      4: lineIn.b2Sum <= v;
      5: lineIn.gciSum <= v;
      default: lineIn.collision <= v;
    endcase
    hold(6);
  endtask : setSrc
endmodule : line_model

// *** dv/d_channel_hdlc_regs_tb.sv ***
// self-checking bench for the d-channel hdlc register block
`timescale 1ns/1ps
`include "d_channel_hdlc_map.svh"
module d_channel_hdlc_regs_tb;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rdQ = 1'b0;
  logic [7:0] rdata;
  logic irq;
  d_channel_hdlc_pkg::lineIn_type lineIn;
  d_channel_hdlc_pkg::lineOut_type lineOut;
  logic [7:0] expQ[$];
  logic [7:0] txQ[$];
  logic [7:0] rxB[0:36];
  logic [7:0] modes[3] = '{8'h68, 8'h65, 8'h66};
  logic [7:0] s1[6] = '{8'h04, 8'h08, 8'h10, 8'h02, 8'h01, 8'h04};
  logic [7:0] e1[6] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
  logic [7:0] e2[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
  logic [7:0] s2[6] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h01, 8'h00};
  logic [31:0] seed = 32'hdaf8;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  always #12.5 clock = ~clock;
  d_channel_hdlc_regs #(.T1_UNIT_CYCLES(4)) uut (.clock(clock),
    .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .lineIn(lineIn), .lineOut(lineOut));
  line_model line (.clock(clock), .lineIn(lineIn));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function automatic logic [15:0] crcByte(input logic [15:0] c,
                                          input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ b[i]) ? (c >> 1) ^ `CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crcByte
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wrReg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wrReg
  // expectation is queued now, judged by the watcher when rdata stands
  task automatic rdReg(input logic [5:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    expQ.push_back(e);
    @(posedge clock);
    rd <= 1'b0;
  endtask : rdReg
  task automatic sendTx(input int n, input logic [7:0] cmd);
    logic [15:0] c;
    logic [7:0] b;
    c = `CRC_INIT;
    txQ.push_back(`FLAG_BYTE);
    for (int i = 0; i < n; i++) begin
      b = rnd();
      c = crcByte(c, b);
      txQ.push_back(b);
      wrReg(`TX_FIFO_OFS, b);
    end
    if (cmd[`CMD_XME]) begin
      txQ.push_back(~c[7:0]);
      txQ.push_back(~c[15:8]);
      txQ.push_back(`FLAG_BYTE);
    end
    wrReg(`CMD_OFS, cmd);
  endtask : sendTx
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // bytes after an underrun are not queued, so only queued ones are judged
  always @(posedge clock) begin : watch
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
    rdQ <= rd;
    if (rdQ) chk("rdata", expQ.size() ? expQ.pop_front() : 8'hxx, rdata);
    if (lineOut.txValid === 1'b1 && txQ.size() != 0)
      chk("txByte", txQ.pop_front(), lineOut.txByte);
  end
  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rdReg(`MODE_OFS, 8'h00);
    rdReg(`MASK_OFS, `MASK_RESET);
    rdReg(`STAT_OFS, 8'h00);
    rdReg(6'h3f, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    wrReg(`MASK_OFS, 8'h00);
    repeat (3) @(posedge clock);
    chk("irq", 8'h01, {7'h00, irq});
    rdReg(`STAT_OFS, 8'h20);
    rdReg(`STAT_OFS, 8'h00);
    repeat (3) @(posedge clock);
    chk("irq", 8'h00, {7'h00, irq});
    wrReg(`MODE_OFS, 8'hff);
    rdReg(`MODE_OFS, `MODE_RW);
    foreach (modes[k]) begin
      wrReg(`MODE_OFS, modes[k]);
      repeat (3) @(posedge clock);
      chk("mode pins", {2'b00, modes[k][6:5], modes[k][3:0]},
          {2'b00, lineOut.rxActive, lineOut.txActive, lineOut.lineLoopWithDch,
           lineOut.multiframeOff, lineOut.digitalLoopback,
           lineOut.lineLoopBOnly});
    end
    wrReg(`MODE_OFS, 8'h60);
    for (int n = 3; n <= 32; n += 29) begin
      sendTx(n, 8'h0a);
      line.takes(n + 4);
      rdReg(`STAT_OFS, 8'h20);
    end
    wrReg(`CMD_OFS, 8'h00);
    rdReg(`STAT_OFS, 8'h00);
    repeat (4) wrReg(`TX_FIFO_OFS, rnd());
    wrReg(`CMD_OFS, 8'h01);
    rdReg(`STAT_OFS, 8'h20);
    // txByte holds the last taken byte, so the fill shows after one take
    line.takes(1);
    chk("fill", `FILL_BYTE, lineOut.txByte);
    sendTx(2, 8'h0a);
    line.takes(6);
    rdReg(`STAT_OFS, 8'h20);
    sendTx(2, 8'h08);
    line.takes(4);
    rdReg(`STAT_OFS, 8'h24);
    rdReg(`STAT_OFS, 8'h04);
    rdReg(`EXT_OFS, 8'h40);
    rdReg(`STAT_OFS, 8'h00);
    repeat (2) wrReg(`TX_FIFO_OFS, rnd());
    wrReg(`CMD_OFS, 8'h08);
    line.setSrc(6, 1'b1);
    rdReg(`EXT_OFS, 8'h20);
    rdReg(`STAT_OFS, 8'h20);
    line.setSrc(6, 1'b0);
    for (int i = 0; i < 6; i++) begin
      line.setSrc(i, 1'b1);
      rdReg(`STAT_OFS, s1[i]);
      rdReg(`EXT_OFS, e1[i]);
      line.setSrc(i, 1'b0);
      rdReg(`EXT_OFS, e2[i]);
      rdReg(`STAT_OFS, s2[i]);
      rdReg(`STAT_OFS, 8'h00);
    end
    wrReg(`MASK_OFS, 8'h08);
    line.setSrc(1, 1'b1);
    chk("irq", 8'h00, {7'h00, irq});
    rdReg(`STAT_OFS, 8'h00);
    wrReg(`MASK_OFS, 8'h00);
    line.setSrc(1, 1'b0);
    chk("irq", 8'h01, {7'h00, irq});
    rdReg(`STAT_OFS, 8'h08);
    wrReg(`MODE_OFS, 8'h20);
    line.sendByte(rnd());
    line.sendEnd();
    rdReg(`STAT_OFS, 8'h00);
    wrReg(`MODE_OFS, 8'h60);
    for (int i = 0; i < 37; i++) begin
      rxB[i] = rnd();
      line.sendByte(rxB[i]);
      if (i == 31) begin
        rdReg(`STAT_OFS, 8'h80);
        for (int j = 0; j < 32; j++) rdReg(`RX_FIFO_OFS, rxB[j]);
        wrReg(`CMD_OFS, 8'h80);
      end
    end
    line.sendEnd();
    rdReg(`STAT_OFS, 8'h40);
    rdReg(`RXCNT_OFS, 8'h25);
    for (int j = 32; j < 37; j++) rdReg(`RX_FIFO_OFS, rxB[j]);
    rdReg(`RX_FIFO_OFS, 8'h00);
    wrReg(`CMD_OFS, 8'h80);
    repeat (3) line.sendByte(rnd());
    line.sendEnd();
    // a second end while the first is still shown leaves it pending
    line.sendEnd();
    line.sendByte(rnd());
    rdReg(`EXT_OFS, 8'h80);
    wrReg(`CMD_OFS, 8'h40);
    rdReg(`RX_FIFO_OFS, 8'h00);
    wrReg(`T1CFG_OFS, 8'h03);
    wrReg(`CMD_OFS, 8'h10);
    repeat (2) @(posedge clock);
    chk("timer run", 8'h01, {7'h00, lineOut.timer1Run});
    repeat (30) @(posedge clock);
    chk("timer run", 8'h00, {7'h00, lineOut.timer1Run});
    rdReg(`EXT_OFS, 8'h02);
    wrReg(`CMD_OFS, 8'h10);
    wrReg(`T1CFG_OFS, 8'h03);
    repeat (3) @(posedge clock);
    chk("timer run", 8'h00, {7'h00, lineOut.timer1Run});
    repeat (30) @(posedge clock);
    rdReg(`EXT_OFS, 8'h00);
    repeat (4) @(posedge clock);
    print_verdict();
  end
endmodule : d_channel_hdlc_regs_tb
